// >>> ras_cfg.svh
// Constants of the return address stack: offsets, fields, resets, vectors
`ifndef RAS_CFG_SVH
`define RAS_CFG_SVH

// ----------------------------------------
// Register offsets on the plain port
// ----------------------------------------
`define RAS_ADDR_PTR 4'h0
`define RAS_ADDR_TOP_LOW_BYTE 4'h1
`define RAS_ADDR_TOP_HIGH_BYTE 4'h2
`define RAS_ADDR_TOP_UPPER_BYTE 4'h3

// ----------------------------------------
// Pointer register fields
// ----------------------------------------
`define RAS_FULL_BIT 7
`define RAS_UNF_BIT 6
`define RAS_PTR_MSB 4
`define RAS_PTR_RESET 5'h00
`define RAS_PTR_MAX 5'h1F
`define RAS_PTR_ONE 5'h01

// ----------------------------------------
// Program counter values
// ----------------------------------------
`define RAS_VEC_RESET 21'h000000
`define RAS_VEC_HIGH 21'h000008
`define RAS_VEC_LOW 21'h000018
`define RAS_PC_STEP 21'h000002
`define RAS_PC_ZERO 21'h000000
// First address above implemented program memory
`define RAS_IMPL_END 21'h008000

`endif

// >>> ras_pkg.sv
// Types shared by the return address stack and its users
package ras_pkg;

	// ----------------------------------------
	// Sequencer operations
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_CALL = 4'b0001,
		OP_RELATIVE_CALL = 4'b0010,
		OP_INT_ACK = 4'b0011,
		OP_RETURN = 4'b0100,
		OP_RETURN_WITH_LITERAL = 4'b0101,
		OP_RETURN_FROM_INTERRUPT = 4'b0110,
		OP_PUSH = 4'b0111,
		OP_POP = 4'b1000
	} op_t;

	typedef struct packed {
		op_t op;
		logic fast;
		logic int_high;
		logic [20:0] pc;
	} req_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] working_register;
		logic [3:0] bank_select_register;
	} shadow_t;

	typedef struct packed {
		logic valid;
		logic [20:0] addr;
	} pc_load_t;

	typedef struct packed {
		logic valid;
		shadow_t regs;
	} restore_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

endpackage : ras_pkg

// >>> return_address_stack.sv
// Return address stack with pointer register and fast shadow stack
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "ras_cfg.svh"
`default_nettype none

module return_address_stack
	import ras_pkg::*;
(
	// Clock and resets
	input wire logic clk,
	input wire logic resetn,
	input wire logic dev_reset_n,
	// Configuration
	input wire logic stack_fault_reset_enable,
	// Sequencer requests
	input wire req_t req,
	input wire shadow_t core_regs,
	// Program fetch
	input wire logic [20:0] fetch_addr,
	input wire logic [15:0] fetch_word,
	output logic [15:0] fetch_word_ff,
	// Program counter and shadow restore
	output pc_load_t pc_load_ff,
	output restore_t restore_ff,
	output logic fault_reset_ff,
	// Register port
	input wire bus_req_t bus,
	output logic [7:0] rd_data_ff
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_push(input op_t op);
		is_push = (op == OP_CALL) || (op == OP_RELATIVE_CALL)
			|| (op == OP_INT_ACK) || (op == OP_PUSH);
	endfunction : is_push

	function automatic logic is_pop(input op_t op);
		is_pop = (op == OP_RETURN) || (op == OP_RETURN_WITH_LITERAL)
			|| (op == OP_RETURN_FROM_INTERRUPT) || (op == OP_POP);
	endfunction : is_pop

	function automatic logic [20:0] byte_merge(
		input logic [20:0] word,
		input logic [3:0] addr,
		input logic [7:0] data
	);
		logic [20:0] w;
		w = word;
		if (addr == `RAS_ADDR_TOP_LOW_BYTE) begin
			w[7:0] = data;
		end else if (addr == `RAS_ADDR_TOP_HIGH_BYTE) begin
			w[15:8] = data;
		end else begin
			w[20:16] = data[4:0];
		end
		byte_merge = w;
	endfunction : byte_merge

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [4:0] ptr_ff;
	logic full_ff;
	logic unf_ff;
	shadow_t shadow_ff;
	// Pointer zero has no storage, so the array starts at one
	logic [20:0] stack_mem [1:31];

	logic [4:0] nxt_ptr;
	logic nxt_full;
	logic nxt_unf;
	pc_load_t nxt_pc_load;
	restore_t nxt_restore;
	logic [7:0] nxt_rd_data;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	wire active = dev_reset_n;
	wire push_any = active & is_push(req.op);
	wire pop_any = active & is_pop(req.op);
	wire op_int = active & (req.op == OP_INT_ACK);
	wire op_call = active & ((req.op == OP_CALL) || (req.op == OP_RELATIVE_CALL));
	wire pop_loads_pc = pop_any & (req.op != OP_POP);
	wire ret_fast = active & req.fast
		& ((req.op == OP_RETURN) || (req.op == OP_RETURN_FROM_INTERRUPT));

	// ----------------------------------------
	// Pointer arithmetic
	// ----------------------------------------
	// zero is empty only
	wire at_zero = (ptr_ff == `RAS_PTR_RESET);
	wire at_top = (ptr_ff == `RAS_PTR_MAX);
	wire [4:0] ptr_inc = 5'(ptr_ff + `RAS_PTR_ONE);
	wire [4:0] ptr_dec = 5'(ptr_ff - `RAS_PTR_ONE);
	wire last_push = push_any & (ptr_inc == `RAS_PTR_MAX);
	wire over_push = push_any & at_top;
	wire underflow = pop_any & at_zero;
	// fault reset on full or underflow
	wire fault = stack_fault_reset_enable & (last_push | over_push | underflow);

	wire [20:0] top_word = at_zero ? `RAS_PC_ZERO : stack_mem[ptr_ff];
	// with fault reset enabled, last push stores PC plus two
	wire [20:0] push_value = (last_push & stack_fault_reset_enable)
		? 21'(req.pc + `RAS_PC_STEP) : req.pc;

	// ----------------------------------------
	// Register port decode
	// ----------------------------------------
	wire hw_op = push_any | pop_any;
	wire sel_ptr = (bus.addr == `RAS_ADDR_PTR);
	wire sel_tos = (bus.addr == `RAS_ADDR_TOP_LOW_BYTE) || (bus.addr == `RAS_ADDR_TOP_HIGH_BYTE)
		|| (bus.addr == `RAS_ADDR_TOP_UPPER_BYTE);
	// Stack operations win over a same-cycle pointer write
	wire sw_ptr_wr = bus.wr & sel_ptr & ~hw_op;
	// flag bits clear only when written zero
	wire clr_full = bus.wr & sel_ptr & ~bus.wdata[`RAS_FULL_BIT];
	wire clr_unf = bus.wr & sel_ptr & ~bus.wdata[`RAS_UNF_BIT];
	// no push write while the pointer is at the top
	wire hw_mem_wr = push_any & ~at_top;
	wire sw_tos_wr = bus.wr & sel_tos & ~at_zero & ~hw_op;
	wire [20:0] tos_merged = byte_merge(top_word, bus.addr, bus.wdata);

	// ----------------------------------------
	// Next pointer
	// ----------------------------------------
	always_comb begin
		nxt_ptr = ptr_ff;
		if (!active) begin
			nxt_ptr = `RAS_PTR_RESET;
		end else if (fault) begin
			nxt_ptr = `RAS_PTR_RESET;
		end else if (push_any & ~at_top) begin
			nxt_ptr = ptr_inc;
		end else if (pop_any & ~at_zero) begin
			nxt_ptr = ptr_dec;
		end else if (sw_ptr_wr) begin
			nxt_ptr = bus.wdata[`RAS_PTR_MSB:0];
		end
	end

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	// set on 31st push, a set beats a clear
	assign nxt_full = (full_ff & ~clr_full) | last_push | over_push;
	assign nxt_unf = (unf_ff & ~clr_unf) | underflow;

	// ----------------------------------------
	// Program counter load
	// ----------------------------------------
	always_comb begin
		nxt_pc_load.valid = 1'b0;
		nxt_pc_load.addr = `RAS_PC_ZERO;
		if (!active) begin
			nxt_pc_load.valid = 1'b1;
			nxt_pc_load.addr = `RAS_VEC_RESET;
		end else if (op_int) begin
			nxt_pc_load.valid = 1'b1;
			nxt_pc_load.addr = req.int_high ? `RAS_VEC_HIGH : `RAS_VEC_LOW;
		end else if (pop_loads_pc) begin
			nxt_pc_load.valid = 1'b1;
			nxt_pc_load.addr = top_word;
		end
	end

	// no path here touches the PC latches
	// bare push and pop load no PC

	// ----------------------------------------
	// Shadow restore
	// ----------------------------------------
	always_comb begin
		nxt_restore.valid = 1'b0;
		nxt_restore.regs = shadow_ff;
		if (ret_fast) begin
			nxt_restore.valid = 1'b1;
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		nxt_rd_data = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				`RAS_ADDR_PTR: nxt_rd_data = {full_ff, unf_ff, 1'b0, ptr_ff};
				`RAS_ADDR_TOP_LOW_BYTE: nxt_rd_data = top_word[7:0];
				`RAS_ADDR_TOP_HIGH_BYTE: nxt_rd_data = top_word[15:8];
				`RAS_ADDR_TOP_UPPER_BYTE: nxt_rd_data = {3'h0, top_word[20:16]};
				default: nxt_rd_data = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ptr_ff <= `RAS_PTR_RESET;
			full_ff <= 1'b0;
			unf_ff <= 1'b0;
		end else begin
			ptr_ff <= nxt_ptr;
			// Only power-on reset or a written zero clears the flags; device reset leaves them
			full_ff <= nxt_full;
			unf_ff <= nxt_unf;
		end
	end

	// ----------------------------------------
	// Stack storage
	// ----------------------------------------
	// No reset on the array: entries above the pointer are dead
	always_ff @(posedge clk) begin
		if (hw_mem_wr) begin
			stack_mem[ptr_inc] <= push_value;
		end else if (sw_tos_wr) begin
			stack_mem[ptr_ff] <= tos_merged;
		end
	end

	// ----------------------------------------
	// Shadow stack
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			shadow_ff <= '0;
		end else if (op_int | (op_call & req.fast)) begin
			shadow_ff <= core_regs;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pc_load_ff <= '{valid: 1'b1, addr: `RAS_VEC_RESET};
			restore_ff <= '0;
			fault_reset_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			fetch_word_ff <= 16'h0000;
		end else begin
			pc_load_ff <= nxt_pc_load;
			restore_ff <= nxt_restore;
			fault_reset_ff <= fault;
			rd_data_ff <= nxt_rd_data;
			// beyond memory reads as a no-op
			fetch_word_ff <= (fetch_addr >= `RAS_IMPL_END) ? 16'h0000 : fetch_word;
		end
	end

endmodule : return_address_stack

`default_nettype wire

// >>> ras_monitor.sv
// Port checker for the return address stack
`timescale 1ns/100ps
`default_nettype none
module ras_monitor
	import ras_pkg::*;
(
	// Clock and resets
	input wire logic clk,
	input wire logic resetn,
	input wire logic dev_reset_n,
	input wire logic stack_fault_reset_enable,
	// Inputs
	input wire req_t req,
	input wire logic [20:0] fetch_addr,
	input wire logic [15:0] fetch_word,
	input wire bus_req_t bus,
	// Outputs
	input wire logic [15:0] fetch_word_ff,
	input wire pc_load_t pc_load_ff,
	input wire restore_t restore_ff,
	input wire logic fault_reset_ff,
	input wire logic [7:0] rd_data_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Faults excluded, their vector is the reset one
	wire logic calm = dev_reset_n && !stack_fault_reset_enable;
	wire logic ret = req.op inside {OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT};
	wire logic fret = req.fast && (req.op == OP_RETURN || req.op == OP_RETURN_FROM_INTERRUPT);

	AST_FETCH_HOLE: assert property (fetch_addr >= 21'h008000 |=> fetch_word_ff == 16'h0000)
		else $error("fetch above memory not zero");
	AST_FETCH_PASS: assert property (fetch_addr < 21'h008000 |=> fetch_word_ff == $past(fetch_word))
		else $error("fetch word lost");
	AST_INT_VEC: assert property (calm && req.op == OP_INT_ACK |=> pc_load_ff.valid
		&& pc_load_ff.addr == ($past(req.int_high) ? 21'h000008 : 21'h000018)) else $error("bad vector");
	AST_DEV_RST: assert property (!dev_reset_n |=> pc_load_ff.valid && pc_load_ff.addr == 21'h000000)
		else $error("no reset vector");
	AST_RET_LOAD: assert property (calm && ret |=> pc_load_ff.valid)
		else $error("return loaded no pc");
	AST_FAST_RET: assert property (calm && fret |=> restore_ff.valid)
		else $error("fast return restored nothing");
	AST_NO_RESTORE: assert property (restore_ff.valid |-> $past(req.fast) && $past(dev_reset_n))
		else $error("restore without fast request");
	AST_FAULT_CAUSE: assert property (fault_reset_ff |-> $past(stack_fault_reset_enable)
		&& $past(req.op) != OP_NONE) else $error("fault without cause");
	AST_RD_IDLE: assert property (!bus.rd |=> rd_data_ff == 8'h00)
		else $error("read data without read");
endmodule : ras_monitor

bind return_address_stack ras_monitor mon (.clk, .resetn, .dev_reset_n, .stack_fault_reset_enable, .req,
	.fetch_addr, .fetch_word, .bus, .fetch_word_ff, .pc_load_ff, .restore_ff, .fault_reset_ff, .rd_data_ff);
`default_nettype wire

// >>> ras_sequencer_model.sv
// Sequencer model issuing stack requests and core registers
`timescale 1ns/100ps
`default_nettype none
module ras_sequencer_model
	import ras_pkg::*;
(
	// Clock
	input wire logic clk,
	// Core side
	output var req_t req,
	output var shadow_t core_regs
);
	initial req = '0;
	initial core_regs = '0;
	// One request held for one edge; ends at the falling edge
	task automatic issue(input op_t op, input logic fast, input logic hi, input logic [20:0] pc,
		input shadow_t regs = '0);
		@(posedge clk);
		req <= '{op: op, fast: fast, int_high: hi, pc: pc};
		core_regs <= regs;
		@(posedge clk);
		req.op <= OP_NONE;
		@(negedge clk);
	endtask : issue
endmodule : ras_sequencer_model
`default_nettype wire

// >>> return_address_stack_tb.sv
// Testbench of the return address stack
`timescale 1ns/100ps
`include "ras_cfg.svh"
`default_nettype none
module return_address_stack_tb
	import ras_pkg::*;
;
	logic clk, resetn, dev_reset_n, sfre, fault_reset_ff;
	logic [20:0] fetch_addr;
	logic [15:0] fetch_word, fetch_word_ff;
	logic [7:0] rd_data_ff;
	bus_req_t bus;
	req_t req;
	shadow_t core_regs;
	pc_load_t pc_load_ff;
	restore_t restore_ff;
	int n_errors = 0;
	int total_checks = 0;
	// Fetch address, word, expected registered word
	logic [52:0] rows [4] = '{{21'h000100, 16'hABCD, 16'hABCD}, {21'h007FFE, 16'h1234, 16'h1234},
		{21'h008000, 16'h5555, 16'h0000}, {21'h1FFFFE, 16'hFFFF, 16'h0000}};

	return_address_stack dut (.clk, .resetn, .dev_reset_n, .stack_fault_reset_enable(sfre), .req, .core_regs,
		.fetch_addr, .fetch_word, .fetch_word_ff, .pc_load_ff, .restore_ff, .fault_reset_ff, .bus, .rd_data_ff);
	ras_sequencer_model seq (.clk, .req, .core_regs);

	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus_op(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
	endtask : bus_op
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		bus_op(1'b0, a, 8'h00);
		check(rd_data_ff, e);
	endtask : rd
	task automatic pc(input logic [20:0] e);
		check({pc_load_ff.valid, pc_load_ff.addr}, {1'b1, e});
	endtask : pc
	task automatic en(input logic v);
		@(posedge clk);
		sfre <= v;
	endtask : en
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial begin
		#50000;
		n_errors++;
		end_sim();
	end

	initial begin
		resetn = 0;
		dev_reset_n = 1;
		sfre = 0;
		fetch_addr = '0;
		fetch_word = '0;
		bus = '0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		pc(21'h000000);
		@(posedge clk);
		resetn <= 1;
		foreach (rows[i]) begin
			@(posedge clk);
			{fetch_addr, fetch_word} <= rows[i][52:16];
			@(posedge clk);
			@(negedge clk);
			check(fetch_word_ff, rows[i][15:0]);
		end
		rd(`RAS_ADDR_PTR, 8'h00);
		rd(4'hF, 8'h00);
		seq.issue(OP_CALL, 0, 0, 21'h000124);
		rd(`RAS_ADDR_PTR, 8'h01);
		seq.issue(OP_RELATIVE_CALL, 0, 0, 21'h1ABCDE);
		rd(`RAS_ADDR_TOP_UPPER_BYTE, 8'h1A);
		rd(`RAS_ADDR_TOP_HIGH_BYTE, 8'hBC);
		bus_op(1, `RAS_ADDR_TOP_LOW_BYTE, 8'h55);
		seq.issue(OP_RETURN, 0, 0, 21'h0);
		pc(21'h1ABC55);
		seq.issue(OP_RETURN_WITH_LITERAL, 0, 0, 21'h0);
		pc(21'h000124);
		seq.issue(OP_RETURN_FROM_INTERRUPT, 0, 0, 21'h0);
		pc(21'h000000);
		rd(`RAS_ADDR_PTR, 8'h40);
		bus_op(1, `RAS_ADDR_PTR, 8'h00);
		rd(`RAS_ADDR_PTR, 8'h00);
		seq.issue(OP_INT_ACK, 0, 0, 21'h000300, 20'hAAAA1);
		pc(21'h000018);
		seq.issue(OP_INT_ACK, 0, 1, 21'h000400, 20'hBBBB2);
		pc(21'h000008);
		seq.issue(OP_RETURN_FROM_INTERRUPT, 1, 0, 21'h0, 20'hCCCC3);
		check(restore_ff, {1'b1, 20'hBBBB2});
		pc(21'h000400);
		seq.issue(OP_CALL, 1, 0, 21'h000500, 20'hDDDD4);
		seq.issue(OP_RETURN, 1, 0, 21'h0, 20'hEEEE5);
		check(restore_ff, {1'b1, 20'hDDDD4});
		seq.issue(OP_PUSH, 0, 0, 21'h000600);
		rd(`RAS_ADDR_TOP_HIGH_BYTE, 8'h06);
		seq.issue(OP_POP, 0, 0, 21'h0);
		check(pc_load_ff.valid, 0);
		rd(`RAS_ADDR_PTR, 8'h01);
		bus_op(1, `RAS_ADDR_PTR, 8'h1D);
		seq.issue(OP_CALL, 0, 0, 21'h000700);
		seq.issue(OP_CALL, 0, 0, 21'h000702);
		rd(`RAS_ADDR_PTR, 8'h9F);
		seq.issue(OP_CALL, 0, 0, 21'h000704);
		rd(`RAS_ADDR_PTR, 8'h9F);
		rd(`RAS_ADDR_TOP_LOW_BYTE, 8'h02);
		bus_op(1, `RAS_ADDR_PTR, 8'h1F);
		rd(`RAS_ADDR_PTR, 8'h1F);
		en(1);
		bus_op(1, `RAS_ADDR_PTR, 8'h1E);
		seq.issue(OP_CALL, 0, 0, 21'h000800);
		check(fault_reset_ff, 1);
		rd(`RAS_ADDR_PTR, 8'h80);
		bus_op(1, `RAS_ADDR_PTR, 8'h9F);
		rd(`RAS_ADDR_TOP_LOW_BYTE, 8'h02);
		bus_op(1, `RAS_ADDR_PTR, 8'h00);
		seq.issue(OP_RETURN, 0, 0, 21'h0);
		check(fault_reset_ff, 1);
		rd(`RAS_ADDR_PTR, 8'h40);
		en(0);
		bus_op(1, `RAS_ADDR_PTR, 8'h65);
		rd(`RAS_ADDR_PTR, 8'h45);
		@(posedge clk);
		dev_reset_n <= 0;
		@(posedge clk);
		dev_reset_n <= 1;
		rd(`RAS_ADDR_PTR, 8'h40);
		@(posedge clk);
		resetn <= 0;
		repeat (2) @(posedge clk);
		resetn <= 1;
		rd(`RAS_ADDR_PTR, 8'h00);
		bus_op(1, `RAS_ADDR_TOP_LOW_BYTE, 8'hAA);
		rd(`RAS_ADDR_TOP_LOW_BYTE, 8'h00);
		seq.issue(OP_INT_ACK, 0, 0, 21'h000900, 20'h12345);
		seq.issue(OP_RETURN_FROM_INTERRUPT, 1, 0, 21'h0);
		check(restore_ff, {1'b1, 20'h12345});
		pc(21'h000900);
		end_sim();
	end
endmodule : return_address_stack_tb
`default_nettype wire
